// ---- torque_limit_pkg.sv ----
// constants, register map and types for the torque limit selector
package torque_limit_pkg;
	// timing: control cycle derived from the bus clock
	localparam int CLK_PERIOD_NS  = 10;
	localparam int CTRL_PERIOD_NS = 1000;
	localparam int CTRL_DIV       = CTRL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int DIV_W          = 7;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CTRL_DIV - 1);
	// input filter: last count; a new level must hold FILT_LAST+1 samples (control cycles)
	localparam logic [2:0] FILT_LAST = 3'h3;
	// limits in percent of rated torque, one percent per step
	localparam int LIM_W = 10;
	localparam logic [LIM_W-1:0] LIM_INT_RST   = 10'h12C;
	localparam logic [LIM_W-1:0] LIM_EXT_RST   = 10'h064;
	localparam logic [LIM_W-1:0] MOTOR_MAX_RST = 10'h12C;
	localparam logic [LIM_W-1:0] LIM_SAT       = 10'h3FF;
	// analog gain, unsigned fixed point with GAIN_FRAC fraction bits
	localparam int GAIN_W    = 16;
	localparam int GAIN_FRAC = 8;
	localparam logic [GAIN_W-1:0] GAIN_RST = 16'h0100;
	// terminals
	localparam int N_IN   = 8;
	localparam int SEL_W  = 3;
	localparam int N_OUT  = 4;
	localparam int OSEL_W = 2;
	localparam logic [SEL_W-1:0] FWD_TERM_DEF = 3'h0;
	localparam logic [SEL_W-1:0] REV_TERM_DEF = 3'h1;
	// register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] A_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] A_FWD_INT   = 8'h04;
	localparam logic [ADDR_W-1:0] A_REV_INT   = 8'h08;
	localparam logic [ADDR_W-1:0] A_FWD_EXT   = 8'h0C;
	localparam logic [ADDR_W-1:0] A_REV_EXT   = 8'h10;
	localparam logic [ADDR_W-1:0] A_GAIN      = 8'h14;
	localparam logic [ADDR_W-1:0] A_MOTOR_MAX = 8'h18;
	localparam logic [ADDR_W-1:0] A_IN_MAP    = 8'h1C;
	localparam logic [ADDR_W-1:0] A_OUT_MAP   = 8'h20;
	localparam logic [ADDR_W-1:0] A_STATUS    = 8'h24;
	localparam logic [ADDR_W-1:0] A_IRQ_STAT  = 8'h28;
	localparam logic [ADDR_W-1:0] A_IRQ_MASK  = 8'h2C;
	// field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_OPT_LSB  = 2;
	localparam int OPT_W         = 4;
	localparam int IN_FWD_LSB    = 0;
	localparam int IN_REV_LSB    = 4;
	localparam int OUT_SEL_LSB   = 0;
	localparam int OUT_EN_BIT    = 4;
	localparam int ST_FWD_LSB    = 0;
	localparam int ST_REV_LSB    = 16;
	localparam int ST_LIMIT_BIT  = 28;
	localparam int ST_FEXT_BIT   = 29;
	localparam int ST_REXT_BIT   = 30;
	// interrupt bits
	localparam int IRQ_W     = 3;
	localparam int IRQ_LIMIT = 0;
	localparam int IRQ_FEXT  = 1;
	localparam int IRQ_REXT  = 2;
	// ahb
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// speed control option field values
	localparam logic [OPT_W-1:0] OPT_NONE     = 4'h0;
	localparam logic [OPT_W-1:0] OPT_TLIM     = 4'h1;
	localparam logic [OPT_W-1:0] OPT_TFF      = 4'h2;
	localparam logic [OPT_W-1:0] OPT_TLIM_EXT = 4'h3;
	typedef enum logic [1:0] {
		MODE_SPEED    = 2'b00,
		MODE_POSITION = 2'b01,
		MODE_TORQUE   = 2'b10
	} ctrl_mode_t;
endpackage

// ---- torque_limit_selector.sv ----
// torque limit selection with ahb-lite register access
`timescale 1ns/10ps
module torque_limit_selector
	import torque_limit_pkg::*;
#(
	parameter bit TWO_AXIS = 1'b0
) (
	// clock and reset
	input  wire logic                     hclk,
	input  wire logic                     hresetn,
	// ahb-lite slave
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic                     hready,
	input  wire logic [31:0]              hwdata,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic      [31:0]              hrdata,
	// discrete terminals, active low
	input  wire logic [N_IN-1:0]          in_terminal_n,
	output logic      [N_OUT-1:0]         out_terminal_n,
	// control loop
	input  wire logic signed [15:0]       tref_sample,
	input  wire logic signed [15:0]       torque_demand,
	output logic signed [15:0]            torque_cmd,
	output logic signed [15:0]            torque_ff,
	output logic      [LIM_W-1:0]         fwd_limit,
	output logic      [LIM_W-1:0]         rev_limit,
	// interrupt
	output logic                          irq
);

	// settings
	logic [1:0]        ctrl_mode;
	logic [OPT_W-1:0]  option;
	logic [LIM_W-1:0]  fwd_internal_limit_setting;
	logic [LIM_W-1:0]  rev_internal_limit_setting;
	logic [LIM_W-1:0]  fwd_external_limit_setting;
	logic [LIM_W-1:0]  rev_external_limit_setting;
	logic [GAIN_W-1:0] gain;
	logic [LIM_W-1:0]  motor_max;
	logic [SEL_W-1:0]  fwd_sel;
	logic [SEL_W-1:0]  rev_sel;
	logic [OSEL_W-1:0] out_sel;
	logic              out_en;
	logic [IRQ_W-1:0]  irq_stat;
	logic [IRQ_W-1:0]  irq_mask;
	// bus data phase
	logic              wr_pend;
	logic [ADDR_W-1:0] wr_addr;
	// timing and inputs
	logic [DIV_W-1:0]  div_cnt;
	logic              tick;
	logic [N_IN-1:0]   in_s1;
	logic [N_IN-1:0]   in_s2;
	logic [1:0]        raw_n;
	logic [1:0]        filt_n;
	logic [2:0]        fcnt [2];
	logic              fwd_ext_limit_sig_n;
	logic              rev_ext_limit_sig_n;
	// limit datapath
	logic              limiting;
	logic              torque_limiting_out_n;
	logic [LIM_W-1:0]  fwd_int_eff;
	logic [LIM_W-1:0]  rev_int_eff;
	logic [LIM_W-1:0]  ana_lim;
	logic              ana_ok;
	logic [LIM_W-1:0]  next_fwd;
	logic [LIM_W-1:0]  next_rev;
	logic [IRQ_W-1:0]  irq_ev;
	logic [IRQ_W-1:0]  irq_clr;

	function automatic logic [LIM_W-1:0] lim_min(input logic [LIM_W-1:0] a, input logic [LIM_W-1:0] b);
		return (a < b) ? a : b;
	endfunction

	// magnitude times gain, saturated to the limit width
	function automatic logic [LIM_W-1:0] ana_scale(input logic signed [15:0] r, input logic [GAIN_W-1:0] g);
		logic [16:0] mag;
		logic [32:0] prod;
		mag  = r[15] ? 17'(-$signed({r[15], r})) : {1'b0, r};
		prod = 33'(mag * g) >> GAIN_FRAC;
		return (|prod[32:LIM_W]) ? LIM_SAT : prod[LIM_W-1:0];
	endfunction

	function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == A_CTRL) begin
			d[CTRL_MODE_LSB +: 2] = ctrl_mode;
			d[CTRL_OPT_LSB +: OPT_W] = option;
		end else if (a == A_FWD_INT) begin
			d[LIM_W-1:0] = fwd_internal_limit_setting;
		end else if (a == A_REV_INT) begin
			d[LIM_W-1:0] = rev_internal_limit_setting;
		end else if (a == A_FWD_EXT) begin
			d[LIM_W-1:0] = fwd_external_limit_setting;
		end else if (a == A_REV_EXT) begin
			d[LIM_W-1:0] = rev_external_limit_setting;
		end else if (a == A_GAIN) begin
			d[GAIN_W-1:0] = gain;
		end else if (a == A_MOTOR_MAX) begin
			d[LIM_W-1:0] = motor_max;
		end else if (a == A_IN_MAP) begin
			d[IN_FWD_LSB +: SEL_W] = fwd_sel;
			d[IN_REV_LSB +: SEL_W] = rev_sel;
		end else if (a == A_OUT_MAP) begin
			d[OUT_SEL_LSB +: OSEL_W] = out_sel;
			d[OUT_EN_BIT] = out_en;
		end else if (a == A_STATUS) begin
			d[ST_FWD_LSB +: LIM_W] = fwd_limit;
			d[ST_REV_LSB +: LIM_W] = rev_limit;
			d[ST_LIMIT_BIT] = limiting;
			d[ST_FEXT_BIT] = ~fwd_ext_limit_sig_n;
			d[ST_REXT_BIT] = ~rev_ext_limit_sig_n;
		end else if (a == A_IRQ_STAT) begin
			d[IRQ_W-1:0] = irq_stat;
		end else if (a == A_IRQ_MASK) begin
			d[IRQ_W-1:0] = irq_mask;
		end
		return d;
	endfunction

	// zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// address phase: reads are fetched here so hrdata comes from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hrdata  <= 32'h0000_0000;
		end else if (hsel && htrans[1] && hready && hsize == HSIZE_WORD) begin
			wr_pend <= hwrite;
			wr_addr <= haddr[ADDR_W-1:0];
			if (!hwrite) begin
				hrdata <= rd_mux(haddr[ADDR_W-1:0]);
			end
		end else begin
			wr_pend <= 1'b0;
		end
	end

	// settings written in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_mode                  <= MODE_SPEED;
			option                     <= OPT_NONE;
			fwd_internal_limit_setting <= LIM_INT_RST;
			rev_internal_limit_setting <= LIM_INT_RST;
			fwd_external_limit_setting <= LIM_EXT_RST;
			rev_external_limit_setting <= LIM_EXT_RST;
			gain                       <= GAIN_RST;
			motor_max                  <= MOTOR_MAX_RST;
			fwd_sel                    <= FWD_TERM_DEF;
			rev_sel                    <= REV_TERM_DEF;
			out_sel                    <= '0;
			out_en                     <= 1'b0;
			irq_mask                   <= '0;
		end else if (wr_pend) begin
			if (wr_addr == A_CTRL) begin
				ctrl_mode <= hwdata[CTRL_MODE_LSB +: 2];
				option    <= hwdata[CTRL_OPT_LSB +: OPT_W];
			end else if (wr_addr == A_FWD_INT) begin
				fwd_internal_limit_setting <= hwdata[LIM_W-1:0];
			end else if (wr_addr == A_REV_INT) begin
				rev_internal_limit_setting <= hwdata[LIM_W-1:0];
			end else if (wr_addr == A_FWD_EXT) begin
				fwd_external_limit_setting <= hwdata[LIM_W-1:0];
			end else if (wr_addr == A_REV_EXT) begin
				rev_external_limit_setting <= hwdata[LIM_W-1:0];
			end else if (wr_addr == A_GAIN) begin
				gain <= hwdata[GAIN_W-1:0];
			end else if (wr_addr == A_MOTOR_MAX) begin
				motor_max <= hwdata[LIM_W-1:0];
			end else if (wr_addr == A_IN_MAP && TWO_AXIS) begin
				fwd_sel <= hwdata[IN_FWD_LSB +: SEL_W];
				rev_sel <= hwdata[IN_REV_LSB +: SEL_W];
			end else if (wr_addr == A_OUT_MAP) begin
				out_sel <= hwdata[OUT_SEL_LSB +: OSEL_W];
				out_en  <= hwdata[OUT_EN_BIT];
			end else if (wr_addr == A_IRQ_MASK) begin
				irq_mask <= hwdata[IRQ_W-1:0];
			end
		end
	end

	// control cycle enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
		end
	end
	assign tick = (div_cnt == DIV_LAST);

	// pins pass two flops before anything looks at them
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_s1 <= '1;
			in_s2 <= '1;
		end else begin
			in_s1 <= in_terminal_n;
			in_s2 <= in_s1;
		end
	end

	// one terminal may feed both functions; each just follows its level
	assign raw_n[0] = in_s2[fwd_sel];
	assign raw_n[1] = in_s2[rev_sel];

	// a new level must hold FILT_LAST+1 control cycles; rejects contact bounce
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			filt_n  <= 2'b11;
			fcnt[0] <= '0;
			fcnt[1] <= '0;
		end else if (tick) begin
			for (int i = 0; i < 2; i++) begin
				if (raw_n[i] == filt_n[i]) begin
					fcnt[i] <= '0;
				end else if (fcnt[i] == FILT_LAST) begin
					filt_n[i] <= raw_n[i];
					fcnt[i]   <= '0;
				end else begin
					fcnt[i] <= fcnt[i] + 1'b1;
				end
			end
		end
	end
	assign fwd_ext_limit_sig_n = filt_n[0];
	assign rev_ext_limit_sig_n = filt_n[1];

	// limit selection, combinational part
	always_comb begin
		fwd_int_eff = lim_min(fwd_internal_limit_setting, motor_max);
		rev_int_eff = lim_min(rev_internal_limit_setting, motor_max);
		ana_lim     = ana_scale(tref_sample, gain);
		ana_ok      = (ctrl_mode != MODE_TORQUE);
		next_fwd    = fwd_int_eff;
		next_rev    = rev_int_eff;
		if (!fwd_ext_limit_sig_n) begin
			next_fwd = lim_min(next_fwd, fwd_external_limit_setting);
		end
		if (!rev_ext_limit_sig_n) begin
			next_rev = lim_min(next_rev, rev_external_limit_setting);
		end
		if (ana_ok && option == OPT_TLIM) begin
			next_fwd = lim_min(next_fwd, ana_lim);
			next_rev = lim_min(next_rev, ana_lim);
		end
		if (ana_ok && option == OPT_TLIM_EXT && !fwd_ext_limit_sig_n) begin
			next_fwd = lim_min(next_fwd, ana_lim);
		end
		if (ana_ok && option == OPT_TLIM_EXT && !rev_ext_limit_sig_n) begin
			next_rev = lim_min(next_rev, ana_lim);
		end
	end

	// limits, clamped command and limiting flag, once per control cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fwd_limit  <= LIM_INT_RST;
			rev_limit  <= LIM_INT_RST;
			torque_cmd <= 16'h0000;
			limiting   <= 1'b0;
		end else if (tick) begin
			fwd_limit <= next_fwd;
			rev_limit <= next_rev;
			if (torque_demand > $signed({6'h00, next_fwd})) begin
				torque_cmd <= $signed({6'h00, next_fwd});
				limiting   <= 1'b1;
			end else if (torque_demand < -$signed({6'h00, next_rev})) begin
				torque_cmd <= -$signed({6'h00, next_rev});
				limiting   <= 1'b1;
			end else begin
				torque_cmd <= torque_demand;
				limiting   <= 1'b0;
			end
		end
	end
	assign torque_limiting_out_n = ~limiting;

	// feed-forward only when the analog input is not a limit source
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			torque_ff <= 16'h0000;
		end else begin
			torque_ff <= (option == OPT_TFF) ? tref_sample : 16'h0000;
		end
	end

	// indicator appears only on the mapped terminal; others stay off (high)
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_terminal_n <= '1;
		end else begin
			for (int i = 0; i < N_OUT; i++) begin
				out_terminal_n[i] <= !(out_en && out_sel == OSEL_W'(i)) || torque_limiting_out_n;
			end
		end
	end

	// sticky events, write one to clear; a new event wins over the clear
	assign irq_ev[IRQ_LIMIT] = tick && !limiting &&
		((torque_demand > $signed({6'h00, next_fwd})) || (torque_demand < -$signed({6'h00, next_rev})));
	assign irq_ev[IRQ_FEXT]  = tick && filt_n[0] && !raw_n[0] && fcnt[0] == FILT_LAST;
	assign irq_ev[IRQ_REXT]  = tick && filt_n[1] && !raw_n[1] && fcnt[1] == FILT_LAST;
	assign irq_clr = (wr_pend && wr_addr == A_IRQ_STAT) ? hwdata[IRQ_W-1:0] : '0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
		end
	end
	assign irq = |(irq_stat & irq_mask);

	// checks
	torque_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick && ctrl_mode == MODE_TORQUE && fwd_ext_limit_sig_n |=> fwd_limit == $past(fwd_int_eff))
		else $error("analog limit applied in torque control");
	both_sides_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick && ana_ok && option == OPT_TLIM && ana_lim < fwd_int_eff && ana_lim < rev_int_eff
		|=> fwd_limit == rev_limit && fwd_limit == $past(ana_lim))
		else $error("analog limit not equal on both sides");
	combined_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick && option == OPT_TLIM_EXT && fwd_ext_limit_sig_n |=> fwd_limit == $past(fwd_int_eff))
		else $error("combined mode used analog without external input");
	fwd_ext_cap_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick && !fwd_ext_limit_sig_n |=> fwd_limit <= $past(fwd_external_limit_setting))
		else $error("forward external limit not applied");
	rev_int_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick && rev_ext_limit_sig_n && option == OPT_NONE |=> rev_limit == $past(rev_int_eff))
		else $error("reverse limit wrong with input off");
	indicator_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick && torque_demand > $signed({6'h00, next_fwd})
		|=> !torque_limiting_out_n && torque_cmd == $past($signed({6'h00, next_fwd})))
		else $error("indicator not asserted while limiting");
	unmapped_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!out_en |=> out_terminal_n == {N_OUT{1'b1}})
		else $error("indicator driven on unmapped terminal");
	ff_exclusive_a: assert property (@(posedge hclk) disable iff (!hresetn)
		option != OPT_TFF |=> torque_ff == 16'sh0000)
		else $error("feed-forward active with analog used as limit");
	sticky_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_ev[IRQ_FEXT] |=> irq_stat[IRQ_FEXT])
		else $error("event flag lost");
	motor_clamp_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick |=> fwd_limit <= $past(motor_max) && rev_limit <= $past(motor_max))
		else $error("limit above motor maximum");
endmodule

// ---- host_ctrl_model.sv ----
// host motion controller model driving the discrete limit terminals
`timescale 1ns/10ps
module host_ctrl_model
	import torque_limit_pkg::*;
(
	// clock
	input  wire logic            hclk,
	// requested limit states, high = limit on
	input  wire logic            fwd_on,
	input  wire logic            rev_on,
	// terminals toward the drive, active low
	output logic      [N_IN-1:0] in_terminal_n
);
	logic [N_IN-1:0] pins;

	// single-axis wiring: limit requests sit on the fixed terminals; idle ones rest high
	always @(posedge hclk) begin
		pins = '1;
		pins[FWD_TERM_DEF] = ~fwd_on;
		pins[REV_TERM_DEF] = ~rev_on;
		in_terminal_n <= pins;
	end
endmodule

// ---- tb_top.sv ----
// self-checking bench for the torque limit selector
`timescale 1ns/10ps
module tb_top
	import torque_limit_pkg::*;
;
	localparam logic [9:0]  P300 = 10'h12C;
	localparam logic [9:0]  P100 = 10'h064;
	localparam logic [15:0] G1   = 16'h0100;
	localparam logic [15:0] Z    = 16'h0000;
	typedef struct packed {
		logic [1:0]         mode;
		logic [3:0]         opt;
		logic [9:0]         fi, ri, fe, re;
		logic [15:0]        gain;
		logic signed [15:0] tref, dem;
		logic               fp, rp;
		logic [9:0]         ef, er;
		logic signed [15:0] cmd;
	} row_t;
	logic                   hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, fwd_on, rev_on;
	logic        [31:0]     haddr, hwdata, hrdata, rd;
	logic        [1:0]      htrans;
	logic        [2:0]      hsize;
	logic        [N_IN-1:0] in_terminal_n;
	logic        [N_OUT-1:0] out_terminal_n;
	logic signed [15:0]     tref_sample, torque_demand, torque_cmd, torque_ff;
	logic        [LIM_W-1:0] fwd_limit, rev_limit;
	int                     error_cnt, check_count;
	// mode opt fi ri fe re gain tref demand fwd rev | fwd_limit rev_limit torque_cmd
	row_t rows [10] = '{
		'{MODE_SPEED,OPT_NONE,10'h0C8,10'h096,P100,P100,G1,Z,16'h00FA,1'b0,1'b0,10'h0C8,10'h096,16'h00C8},
		'{MODE_SPEED,OPT_NONE,10'h1F4,P300,P100,P100,G1,Z,16'hFE70,1'b0,1'b0,P300,P300,16'hFED4},
		'{MODE_POSITION,OPT_NONE,P100,P100,10'h050,10'h078,G1,Z,16'h0032,1'b1,1'b1,10'h050,P100,16'h0032},
		'{MODE_SPEED,OPT_TLIM,P300,P300,P100,P100,G1,16'hFFC4,16'hFFBA,1'b0,1'b0,10'h03C,10'h03C,16'hFFC4},
		'{MODE_TORQUE,OPT_TLIM,P300,P300,P100,P100,G1,16'h003C,16'h00FA,1'b0,1'b0,P300,P300,16'h00FA},
		'{MODE_POSITION,OPT_TLIM,P300,P300,P100,P100,16'h0200,16'h0028,16'h005A,1'b0,1'b0,10'h050,10'h050,16'h0050},
		'{MODE_SPEED,OPT_TLIM_EXT,P300,P300,P100,10'h032,G1,16'h0046,16'hFF38,1'b1,1'b0,10'h046,P300,16'hFF38},
		'{MODE_SPEED,OPT_TFF,P300,P300,P100,P100,G1,16'h0032,16'h000A,1'b0,1'b0,P300,P300,16'h000A},
		'{MODE_SPEED,OPT_TLIM_EXT,P300,P300,10'h028,10'h0C8,G1,16'h005A,16'hFF6A,1'b1,1'b1,10'h028,10'h05A,16'hFFA6},
		'{MODE_SPEED,OPT_TLIM,P300,P300,P100,P100,16'hFFFF,16'h8000,16'h0190,1'b0,1'b0,P300,P300,16'h012C}
	};
	logic [7:0]  ra [13] = '{A_CTRL, A_FWD_INT, A_REV_INT, A_FWD_EXT, A_REV_EXT, A_GAIN, A_MOTOR_MAX,
		A_IN_MAP, A_OUT_MAP, A_IRQ_STAT, A_IRQ_MASK, A_STATUS, 8'h30};
	logic [31:0] rv [13] = '{32'h0, 32'h12C, 32'h12C, 32'h64, 32'h64, 32'h100, 32'h12C,
		32'h10, 32'h0, 32'h0, 32'h0, 32'h012C012C, 32'h0};

	torque_limit_selector dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.in_terminal_n(in_terminal_n), .out_terminal_n(out_terminal_n),
		.tref_sample(tref_sample), .torque_demand(torque_demand), .torque_cmd(torque_cmd),
		.torque_ff(torque_ff), .fwd_limit(fwd_limit), .rev_limit(rev_limit), .irq(irq)
	);
	host_ctrl_model host_u (.hclk(hclk), .fwd_on(fwd_on), .rev_on(rev_on), .in_terminal_n(in_terminal_n));

	// 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	// hang guard: a stuck run counts as a mismatch
	initial begin
		repeat (100000) @(posedge hclk);
		error_cnt++;
		finish_test;
	end

	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			error_cnt++;
		end
	endtask

	// bounded wait for the slave to accept a phase
	task automatic wait_hready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 64) begin
			@(posedge hclk);
			n++;
		end
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			finish_test;
		end
	endtask

	// one single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= HSIZE_WORD;
		wait_hready;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_hready;
		rd = hrdata;
	endtask

	// whole control cycles, the pace at which limits are recomputed
	task automatic ticks(input int k);
		repeat (k * CTRL_DIV) @(posedge hclk);
	endtask

	initial begin
		{hresetn, hsel, hwrite, fwd_on, rev_on} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = HSIZE_WORD;
		{tref_sample, torque_demand} = '0;
		{error_cnt, check_count} = '0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// table of settings, pin states and the limits they must give
		for (int i = 0; i < 10; i++) begin
			bus(1'b1, A_CTRL, {26'h0, rows[i].opt, rows[i].mode});
			bus(1'b1, A_FWD_INT, {22'h0, rows[i].fi});
			bus(1'b1, A_REV_INT, {22'h0, rows[i].ri});
			bus(1'b1, A_FWD_EXT, {22'h0, rows[i].fe});
			bus(1'b1, A_REV_EXT, {22'h0, rows[i].re});
			bus(1'b1, A_GAIN, {16'h0, rows[i].gain});
			tref_sample <= rows[i].tref;
			torque_demand <= rows[i].dem;
			fwd_on <= rows[i].fp;
			rev_on <= rows[i].rp;
			ticks(7);
			chk(32'(fwd_limit), 32'(rows[i].ef));
			chk(32'(rev_limit), 32'(rows[i].er));
			chk(32'(torque_cmd), 32'(rows[i].cmd));
			chk(32'(torque_ff), 32'(rows[i].opt == OPT_TFF ? rows[i].tref : Z));
			bus(1'b0, A_STATUS, 32'h0);
			chk(rd & 32'h03FF03FF, {6'h00, rows[i].er, 6'h00, rows[i].ef});
			$display("row %0d done", i);
		end
		// short pulse on the forward input is filtered, a held one is taken
		bus(1'b1, A_CTRL, 32'h0);
		bus(1'b1, A_GAIN, 32'h100);
		torque_demand <= Z;
		fwd_on <= 1'b0;
		rev_on <= 1'b0;
		ticks(7);
		bus(1'b1, A_IRQ_STAT, 32'h7);
		fwd_on <= 1'b1;
		ticks(2);
		fwd_on <= 1'b0;
		ticks(7);
		bus(1'b0, A_IRQ_STAT, 32'h0);
		chk(rd, 32'h0);
		chk(32'(fwd_limit), 32'h12C);
		fwd_on <= 1'b1;
		ticks(7);
		bus(1'b0, A_IRQ_STAT, 32'h0);
		chk(rd, 32'h2);
		chk(32'(fwd_limit), 32'h064);
		$display("filter test done");
		// limiting indicator, its terminal mapping and the interrupt path
		fwd_on <= 1'b0;
		bus(1'b1, A_FWD_INT, 32'h64);
		ticks(7);
		bus(1'b1, A_IRQ_STAT, 32'h7);
		torque_demand <= 16'sh00C8;
		ticks(3);
		chk(32'(out_terminal_n), 32'hF);
		chk(32'(torque_cmd), 32'h64);
		chk(32'(irq), 32'h0);
		bus(1'b0, A_STATUS, 32'h0);
		chk(32'(rd[ST_LIMIT_BIT]), 32'h1);
		bus(1'b0, A_IRQ_STAT, 32'h0);
		chk(rd, 32'h1);
		bus(1'b1, A_IRQ_MASK, 32'h1);
		@(posedge hclk);
		chk(32'(irq), 32'h1);
		bus(1'b1, A_OUT_MAP, 32'h12);
		repeat (2) @(posedge hclk);
		chk(32'(out_terminal_n), 32'hB);
		bus(1'b1, A_IRQ_STAT, 32'h1);
		@(posedge hclk);
		chk(32'(irq), 32'h0);
		torque_demand <= Z;
		ticks(2);
		chk(32'(out_terminal_n), 32'hF);
		$display("indicator test done");
		// fixed terminal map and an unmapped address
		bus(1'b1, A_IN_MAP, 32'h0);
		bus(1'b1, 8'h30, 32'hFFFFFFFF);
		bus(1'b0, A_IN_MAP, 32'h0);
		chk(rd, 32'h10);
		// reset in mid-run, then every register against its reset value
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk(32'(fwd_limit), 32'h12C);
		chk(32'(out_terminal_n), 32'hF);
		chk(32'(torque_cmd), 32'h0);
		chk(32'(hresp), 32'h0);
		chk(32'(hreadyout), 32'h1);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 13; i++) begin
			bus(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		$display("reset test done");
		finish_test;
	end
endmodule
